// file: inc/uir_pkg.sv
// Notes on behaviour
// [RULE1] Select bit 0 routes a source to line a, 1 routes it to line b.
// [RULE2] Every select bit is 0 after reset, so all sources go to line a.
// [RULE3] A line requests only while the source flag is set and enabled.
// [RULE4] Select bits: 24 mode change, 16 cable change, 9..0 as flag register.
// [RULE5] Enable bits sit at the same positions as the select bits.
// [RULE6] Every enable bit is 0 after reset; no request until enabled.
// [RULE7] Bits 31..25, 23..17, 15..10 of select and enable read 0.
// [RULE8] Read-only control OUT size register shows bytes received on that endpoint.
// [RULE9] Read-only bulk OUT size register shows count of the selected buffer.
// [RULE10] Write-only 64-byte control IN buffer takes the packet data.
// [RULE11] Buffer becomes valid only after the byte count is committed.
// [RULE12] Host ACK after control IN data sets the transmit-done flag.
// [RULE13] Control IN clear bit reinitialises the control IN buffer.
// [RULE14] A received setup packet clears the control IN buffer.
// [RULE15] No control IN transmission while the setup flag stays set.
// [RULE16] Writing 0 clears an event flag; writing 1 does nothing.
// [RULE17] Empty, full, cable and mode status bits follow hardware, not writable.
// [RULE18] Each line is the OR of flag AND enable over sources routed to it.
package uir_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS    = 8'h00;
    localparam logic [7:0] OFS_SELECT   = 8'h04;
    localparam logic [7:0] OFS_ENABLE   = 8'h08;
    localparam logic [7:0] OFS_OUT_SIZE = 8'h0C;
    localparam logic [7:0] OFS_BULK_SZ  = 8'h10;
    localparam logic [7:0] OFS_TX_BUF   = 8'h14;
    localparam logic [7:0] OFS_COMMIT   = 8'h18;
    localparam logic [7:0] OFS_CLEAR    = 8'h1C;

    // Flag bit positions
    localparam int BIT_TX_DONE   = 0;
    localparam int BIT_IN_REQ    = 1;
    localparam int BIT_OUT_DONE  = 2;
    localparam int BIT_SETUP     = 3;
    localparam int BIT_BULK_FULL = 4;
    localparam int BIT_BULK_EMPT = 5;
    localparam int BIT_BULK_REQ  = 6;
    localparam int BIT_BUS_RST   = 7;
    localparam int BIT_INTR_DONE = 8;
    localparam int BIT_INTR_REQ  = 9;
    localparam int BIT_CABLE_F   = 16;
    localparam int BIT_CABLE_MN  = 17;
    localparam int BIT_MODE_F    = 24;
    localparam int BIT_MODE_MN   = 25;
    localparam int BIT_CLR_CTRL  = 0;

    // Masks and reset values
    localparam logic [31:0] SRC_MASK   = 32'h0101_03FF;
    localparam logic [31:0] LEVEL_MASK = 32'h0000_0030;
    localparam logic [31:0] SEL_RESET  = 32'h0000_0000;
    localparam logic [31:0] EN_RESET   = 32'h0000_0000;
    localparam logic [31:0] FLAG_RESET = 32'h0000_0000;

    // Control IN buffer geometry
    localparam int BUF_WORDS = 16;
    localparam int PTR_W     = 5;
    localparam int LEN_W     = 7;

    // Link-side inputs, stable from one link rising edge to the next
    typedef struct packed {
        logic       setup;
        logic       ctrl_in_ack;
        logic       ctrl_out_done;
        logic       ctrl_in_token;
        logic       bulk_in_token_nodata;
        logic       intr_in_token_nodata;
        logic       intr_in_ack;
        logic       bus_reset;
        logic       bulk_in_empty;
        logic       bulk_out_full;
        logic [1:0] mode;
        logic       bulk_sel;
        logic [3:0] rd_idx;
        logic [6:0] ctrl_out_size;
        logic [9:0] bulk_size0;
        logic [9:0] bulk_size1;
    } uir_link_s;

endpackage : uir_pkg

// file: rtl/uir_core.sv
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module uir_core
    import uir_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Cable detect pin, low while connected
    input  wire logic              cable_detect_n_i,
    // Link side
    input  wire logic              link_clk_i,
    input  wire uir_link_s         link_i,
    output logic                   ctrl_in_ready_o,
    output logic      [LEN_W-1:0]  ctrl_in_len_o,
    output logic      [31:0]       tx_rd_data_o,
    // Interrupt lines
    output logic                   irq_line_a_o,
    output logic                   irq_line_b_o
);

    // Bus registers
    logic              ack_reg;
    logic [31:0]       dat_reg;
    logic [31:0]       flags_reg;
    logic [31:0]       select_reg;
    logic [31:0]       enable_reg;
    logic [6:0]        out_size_reg;
    logic [9:0]        bulk_size_reg;
    logic [1:0]        mode_reg;
    logic              cable_mn_reg;
    // Synchronisers
    logic              lclk_meta_reg;
    logic              lclk_s1_reg;
    logic              lclk_s2_reg;
    uir_link_s         link_meta_reg;
    uir_link_s         link_s1_reg;
    logic              cable_meta_reg;
    logic              cable_s1_reg;
    // Control IN buffer
    logic [31:0]       buf_mem [BUF_WORDS];
    logic [PTR_W-1:0]  wr_ptr_reg;
    logic              tx_valid_reg;
    logic [LEN_W-1:0]  tx_len_reg;
    logic [31:0]       tx_rd_reg;
    // Interrupt outputs
    logic              irq_a_reg;
    logic              irq_b_reg;

    // Combinational helpers
    logic              req;
    logic              wr_do;
    logic              link_fall;
    logic [31:0]       lane_mask;
    logic [31:0]       flag_view;
    logic [31:0]       rd_mux;
    logic [31:0]       ev_set;
    logic [31:0]       flag_clr;
    logic [31:0]       flags_next;
    logic [31:0]       pending;
    logic              buf_clear;
    logic              commit_wr;
    logic              ack_done;

    // Bus decode; writes land on the edge where the master sees ack
    assign req   = wb_cyc_i & wb_stb_i;
    assign wr_do = req & wb_we_i & ack_reg;

    // Byte lanes expanded to bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane_mask[8*i +: 8] = {8{wb_sel_i[i]}};
        end
    end

    // Link clock edge detect on lclk_s1_reg and its delayed copy lclk_s2_reg
    assign link_fall = ~lclk_s1_reg & lclk_s2_reg;

    // Two-flop synchronisers for link clock, link bus and cable pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lclk_meta_reg  <= 1'b0;
            lclk_s1_reg    <= 1'b0;
            lclk_s2_reg    <= 1'b0;
            link_meta_reg  <= '0;
            link_s1_reg    <= '0;
            cable_meta_reg <= 1'b1;
            cable_s1_reg   <= 1'b1;
        end else begin
            lclk_meta_reg  <= link_clk_i;
            lclk_s1_reg    <= lclk_meta_reg;
            lclk_s2_reg    <= lclk_s1_reg;
            link_meta_reg  <= link_i;
            link_s1_reg    <= link_meta_reg;
            cable_meta_reg <= cable_detect_n_i;
            cable_s1_reg   <= cable_meta_reg;
        end
    end

    // Hardware status levels; mode sampled mid link period so the bus is settled, cable pin every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg     <= 2'b00;
            cable_mn_reg <= 1'b0;
        end else begin
            cable_mn_reg <= ~cable_s1_reg;
            if (link_fall) begin
                mode_reg <= link_s1_reg.mode;
            end
        end
    end

    // Event set vector; one pulse per link cycle of the event level, cable change one pulse per pin change
    always_comb begin
        ev_set                = '0;
        // [RULE12] transmit-done on host ACK
        ev_set[BIT_TX_DONE]   = link_fall & link_s1_reg.ctrl_in_ack & tx_valid_reg;
        ev_set[BIT_IN_REQ]    = link_fall & link_s1_reg.ctrl_in_token & ~ctrl_in_ready_o;
        ev_set[BIT_OUT_DONE]  = link_fall & link_s1_reg.ctrl_out_done;
        ev_set[BIT_SETUP]     = link_fall & link_s1_reg.setup;
        ev_set[BIT_BULK_REQ]  = link_fall & link_s1_reg.bulk_in_token_nodata;
        ev_set[BIT_BUS_RST]   = link_fall & link_s1_reg.bus_reset;
        ev_set[BIT_INTR_DONE] = link_fall & link_s1_reg.intr_in_ack;
        ev_set[BIT_INTR_REQ]  = link_fall & link_s1_reg.intr_in_token_nodata;
        ev_set[BIT_CABLE_F]   = cable_mn_reg ^ ~cable_s1_reg;
        ev_set[BIT_MODE_F]    = link_fall & (link_s1_reg.mode != mode_reg);
    end

    // Flag update; a set in the clearing cycle survives
    always_comb begin
        flag_clr = '0;
        if (wr_do && wb_adr_i == OFS_FLAGS) begin
            // [RULE16] zero clears, one is ignored
            flag_clr = lane_mask & ~wb_dat_i & SRC_MASK & ~LEVEL_MASK;
        end
        flags_next = ((flags_reg & ~flag_clr) | ev_set) & SRC_MASK & ~LEVEL_MASK;
        // [RULE17] levels follow hardware
        flags_next[BIT_BULK_FULL] = link_s1_reg.bulk_out_full;
        flags_next[BIT_BULK_EMPT] = link_s1_reg.bulk_in_empty;
    end

    // Event flag register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= FLAG_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Read view of flags with read-only status bits folded in
    always_comb begin
        flag_view                                = flags_reg;
        // [RULE17] status bits not writable
        flag_view[BIT_CABLE_MN]                  = cable_mn_reg;
        flag_view[BIT_MODE_MN +: 2]              = mode_reg;
    end

    // Routing select register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // [RULE2] all sources to line a
            select_reg <= SEL_RESET;
        end else if (wr_do && wb_adr_i == OFS_SELECT) begin
            // [RULE4] only documented bits stored
            select_reg <= (select_reg & ~(lane_mask & SRC_MASK))
                        | (wb_dat_i & lane_mask & SRC_MASK);
        end
    end

    // Source enable register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // [RULE6] all sources disabled
            enable_reg <= EN_RESET;
        end else if (wr_do && wb_adr_i == OFS_ENABLE) begin
            // [RULE5] same layout as select
            enable_reg <= (enable_reg & ~(lane_mask & SRC_MASK))
                        | (wb_dat_i & lane_mask & SRC_MASK);
        end
    end

    // Receive size registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_size_reg  <= '0;
            bulk_size_reg <= '0;
        end else if (link_fall) begin
            // [RULE8] latch size with receive done
            if (link_s1_reg.ctrl_out_done) begin
                out_size_reg <= link_s1_reg.ctrl_out_size;
            end
            // [RULE9] size of selected buffer
            bulk_size_reg <= link_s1_reg.bulk_sel ? link_s1_reg.bulk_size1
                                                  : link_s1_reg.bulk_size0;
        end
    end

    // Buffer housekeeping terms
    // [RULE13] clear bit reinitialises buffer
    // [RULE14] setup reception also clears it
    assign buf_clear = (wr_do && wb_adr_i == OFS_CLEAR && wb_sel_i[0]
                        && wb_dat_i[BIT_CLR_CTRL]) | ev_set[BIT_SETUP];
    assign commit_wr = wr_do && wb_adr_i == OFS_COMMIT;
    assign ack_done  = ev_set[BIT_TX_DONE];

    // Buffer word store; writes past 64 bytes are dropped
    always_ff @(posedge clk_i) begin
        if (wr_do && wb_adr_i == OFS_TX_BUF && wr_ptr_reg < PTR_W'(BUF_WORDS)) begin
            // [RULE10] write-only buffer fill
            buf_mem[wr_ptr_reg[3:0]] <= wb_dat_i;
        end
    end

    // Write pointer
    always_ff @(posedge clk_i) begin
        if (rst_i || buf_clear || ack_done) begin
            wr_ptr_reg <= '0;
        end else if (wr_do && wb_adr_i == OFS_TX_BUF && wr_ptr_reg < PTR_W'(BUF_WORDS)) begin
            wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
        end
    end

    // Packet valid and length
    always_ff @(posedge clk_i) begin
        if (rst_i || buf_clear) begin
            tx_valid_reg <= 1'b0;
            tx_len_reg   <= '0;
        end else if (commit_wr) begin
            // [RULE11] count write validates packet
            tx_valid_reg <= 1'b1;
            tx_len_reg   <= wb_dat_i[LEN_W-1:0];
        end else if (ack_done) begin
            tx_valid_reg <= 1'b0;
        end
    end

    // Link read port; registered so the link sees a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_rd_reg <= '0;
        end else begin
            tx_rd_reg <= buf_mem[link_s1_reg.rd_idx];
        end
    end

    // Ready to send; held off while a setup is pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_in_ready_o <= 1'b0;
            ctrl_in_len_o   <= '0;
        end else begin
            // [RULE15] blocked until setup flag cleared
            ctrl_in_ready_o <= tx_valid_reg & ~buf_clear & ~ack_done & ~flags_next[BIT_SETUP];
            ctrl_in_len_o   <= tx_len_reg;
        end
    end
    assign tx_rd_data_o = tx_rd_reg;

    // Interrupt routing; level until flag or enable drops
    // [RULE3] flag and enable gate
    assign pending = flag_view & enable_reg & SRC_MASK;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
        end else begin
            // [RULE1] select picks the line
            // [RULE18] OR over routed sources
            irq_a_reg <= |(pending & ~select_reg);
            irq_b_reg <= |(pending & select_reg);
        end
    end
    assign irq_line_a_o = irq_a_reg;
    assign irq_line_b_o = irq_b_reg;

    // Read mux; unmapped and write-only offsets read zero
    always_comb begin
        unique case (wb_adr_i)
            OFS_FLAGS:    rd_mux = flag_view;
            // [RULE7] reserved bits read zero
            OFS_SELECT:   rd_mux = select_reg & SRC_MASK;
            OFS_ENABLE:   rd_mux = enable_reg & SRC_MASK;
            OFS_OUT_SIZE: rd_mux = {25'h000_0000, out_size_reg};
            OFS_BULK_SZ:  rd_mux = {22'h00_0000, bulk_size_reg};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // Wishbone answer: ack one cycle after request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req && !ack_reg) begin
                dat_reg <= rd_mux;
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

endmodule : uir_core

// file: tb/uir_assertions.sv
`timescale 1ns/1ps
module uir_assertions
    import uir_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Register bus
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Results
    input wire logic        ctrl_in_ready_o,
    input wire logic        irq_line_a_o,
    input wire logic        irq_line_b_o
);
    logic [31:0] sel_sh;
    logic [31:0] en_sh;
    logic        wr_ok;
    logic        rd_ok;

    // Writes land at the edge where ack is seen
    assign wr_ok = wb_ack_o && wb_we_i;
    assign rd_ok = wb_ack_o && !wb_we_i;

    // Shadow of select and enable; full-word writes only in this bench
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_sh <= 32'h0000_0000;
            en_sh  <= 32'h0000_0000;
        end else if (wr_ok && wb_adr_i == OFS_SELECT) begin
            sel_sh <= wb_dat_i & SRC_MASK;
        end else if (wr_ok && wb_adr_i == OFS_ENABLE) begin
            en_sh <= wb_dat_i & SRC_MASK;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Three quiet cycles cover the flag-to-line register stage
    sequence s_none_to_a;
        ((~sel_sh & en_sh) == 32'h0000_0000) [*3];
    endsequence
    sequence s_none_to_b;
        ((sel_sh & en_sh) == 32'h0000_0000) [*3];
    endsequence
    sequence s_flag_read_setup;
        rd_ok && wb_adr_i == OFS_FLAGS && wb_dat_o[BIT_SETUP];
    endsequence

    chk_line_a_route: assert property (s_none_to_a |-> !irq_line_a_o)
        else $error("line a raised with no source routed to it");
    chk_line_b_route: assert property (s_none_to_b |-> !irq_line_b_o)
        else $error("line b raised with no source routed to it");
    chk_no_enable: assert property ((en_sh == 32'h0000_0000) [*3] |-> !(irq_line_a_o || irq_line_b_o))
        else $error("request with every source disabled");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_line_a_o && !irq_line_b_o && !ctrl_in_ready_o)
        else $error("outputs active after reset");
    chk_reserved_zero: assert property (rd_ok && (wb_adr_i == OFS_SELECT || wb_adr_i == OFS_ENABLE) |-> (wb_dat_o & 32'hFEFE_FC00) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    chk_select_back: assert property (rd_ok && wb_adr_i == OFS_SELECT |-> wb_dat_o == sel_sh)
        else $error("select read differs from written bits");
    chk_enable_back: assert property (rd_ok && wb_adr_i == OFS_ENABLE |-> wb_dat_o == en_sh)
        else $error("enable read differs from written bits");
    chk_commit_first: assert property ($rose(ctrl_in_ready_o) |-> $past(wr_ok, 1) || $past(wr_ok, 2) || $past(wr_ok, 3))
        else $error("ready rose without a register write");
    chk_setup_blocks: assert property (s_flag_read_setup |-> !ctrl_in_ready_o)
        else $error("ready while setup flag set");
    chk_level_holds: assert property (irq_line_a_o && !wb_ack_o && !$past(wb_ack_o) |=> irq_line_a_o)
        else $error("line a dropped without a write");
endmodule : uir_assertions

bind uir_core uir_assertions i_chk (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .wb_we_i         (wb_we_i),
    .wb_adr_i        (wb_adr_i),
    .wb_dat_i        (wb_dat_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .ctrl_in_ready_o (ctrl_in_ready_o),
    .irq_line_a_o    (irq_line_a_o),
    .irq_line_b_o    (irq_line_b_o)
);

// file: tb/uir_link_model.sv
`timescale 1ns/1ps
module uir_link_model
    import uir_pkg::*;
(
    // Link clock and bus toward the block
    output logic      link_clk_o,
    output uir_link_s link_o
);
    uir_link_s stat;

    // Transceiver clock runs free, as a real link clock does
    initial begin
        link_clk_o = 1'h0;
        forever #40 link_clk_o = ~link_clk_o;
    end

    // Idle bus at time zero
    initial begin
        stat   = '0;
        link_o = '0;
    end

    // Status fields change on a link rising edge
    task set_stat(input uir_link_s s);
        @(posedge link_clk_o);
        stat = s;
        link_o <= s;
    endtask : set_stat

    // One event lasts exactly one link cycle
    // any of the eight top bus fields, setup down to bus_reset, as an event
    task pulse(input logic [7:0] ev);
        @(posedge link_clk_o);
        link_o <= stat | {ev, 36'h0_0000_0000};
        @(posedge link_clk_o);
        link_o <= stat;
    endtask : pulse
endmodule : uir_link_model

// file: tb/usb_function_irq_route_ep0_in_tb.sv
`timescale 1ns/1ps
module usb_function_irq_route_ep0_in_tb
    import uir_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat_w;
    logic [31:0] dat_r;
    logic        ack;
    logic        lclk;
    uir_link_s   link;
    uir_link_s   st;
    logic        ready;
    logic [6:0]  len;
    logic [31:0] txd;
    logic        irq_a;
    logic        irq_b;
    logic [31:0] q;
    logic [31:0] bitv;
    logic [7:0]  evs [6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
    int          fb [6]  = '{3, 2, 1, 6, 9, 7};
    int          errors  = 0;
    int          n_tests = 0;
    int          cycles  = 0;

    // Cable pin held disconnected
    uir_core i_dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .cable_detect_n_i(1'h1), .link_clk_i(lclk), .link_i(link),
        .ctrl_in_ready_o(ready), .ctrl_in_len_o(len), .tx_rd_data_o(txd),
        .irq_line_a_o(irq_a), .irq_line_b_o(irq_b));

    uir_link_model i_host (.link_clk_o(lclk), .link_o(link));

    // 200 MHz system clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask : check

    // One classic cycle; waits for ack under a bounded count
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat_w} <= {2'h3, w, a, d};
        @(posedge clk);
        while (ack !== 1'h1 && n < 16) begin
            n++;
            @(posedge clk);
        end
        if (n == 16) check(32'h0000_0000, 32'h0000_0001, "no ack");
        q = dat_r;
        {cyc, stb, we} <= 3'h0;
    endtask : wb

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        wb(1'h0, a, 32'h0000_0000);
        check(q & m, e, s);
    endtask : rd

    // Link events cross a two-flop synchroniser
    task settle;
        repeat (16) @(posedge clk);
    endtask : settle

    task load;
        wb(1'h1, OFS_TX_BUF, 32'h1122_3344);
        wb(1'h1, OFS_COMMIT, 32'h0000_0004);
        repeat (3) @(posedge clk);
    endtask : load

    // Hang guard well above the expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            check(32'h0000_0000, 32'h0000_0001, "timeout");
            finish_test();
        end
    end

    initial begin
        {rst, cyc, stb, we, adr, dat_w} = {4'h8, 8'h00, 32'h0000_0000};
        st = '0;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rd(OFS_SELECT, 32'hFFFF_FFFF, 32'h0000_0000, "select reset");
        rd(OFS_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000, "enable reset");
        wb(1'h1, OFS_SELECT, 32'hFFFF_FFFF);
        rd(OFS_SELECT, 32'hFFFF_FFFF, 32'h0101_03FF, "select bits");
        wb(1'h1, OFS_ENABLE, 32'hFFFF_FFFF);
        rd(OFS_ENABLE, 32'hFFFF_FFFF, 32'h0101_03FF, "enable bits");
        wb(1'h1, OFS_ENABLE, 32'h0000_0000);
        wb(1'h1, OFS_FLAGS, 32'h0000_0000);
        // Six link event sources, not transmit done or interrupt done, alternating lines
        for (int k = 0; k < 6; k++) begin
            bitv = 32'h0000_0001 << fb[k];
            wb(1'h1, OFS_ENABLE, 32'h0000_0000);
            i_host.pulse(evs[k]);
            settle();
            rd(OFS_FLAGS, 32'h0000_03CF, bitv, "flag set");
            check({30'h0, irq_b, irq_a}, 32'h0000_0000, "disabled source");
            wb(1'h1, OFS_SELECT, (k % 2) ? bitv : 32'h0000_0000);
            wb(1'h1, OFS_ENABLE, bitv);
            repeat (3) @(posedge clk);
            check({30'h0, irq_b, irq_a}, (k % 2) ? 32'h0000_0002 : 32'h0000_0001, "route");
            wb(1'h1, OFS_FLAGS, 32'hFFFF_FFFF);
            repeat (3) @(posedge clk);
            check({30'h0, irq_b, irq_a}, (k % 2) ? 32'h0000_0002 : 32'h0000_0001, "write one");
            wb(1'h1, OFS_FLAGS, ~bitv);
            repeat (3) @(posedge clk);
            check({30'h0, irq_b, irq_a}, 32'h0000_0000, "flag cleared");
        end
        // Full buffer plus one dropped word
        for (int i = 0; i < 17; i++) wb(1'h1, OFS_TX_BUF, 32'hA5A5_0000 + 32'(i));
        check({31'h0, ready}, 32'h0000_0000, "uncommitted");
        wb(1'h1, OFS_COMMIT, 32'h0000_0040);
        st.rd_idx = 4'hF;
        i_host.set_stat(st);
        settle();
        check({24'h0, ready, len}, 32'h0000_00C0, "committed");
        check(txd, 32'hA5A5_000F, "last word");
        i_host.pulse(8'h40);
        settle();
        rd(OFS_FLAGS, 32'h0000_0001, 32'h0000_0001, "tx done");
        wb(1'h1, OFS_FLAGS, 32'hFFFF_FFFE);
        load();
        check({31'h0, ready}, 32'h0000_0001, "loaded");
        wb(1'h1, OFS_CLEAR, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check({31'h0, ready}, 32'h0000_0000, "clear bit");
        load();
        i_host.pulse(8'h80);
        settle();
        check({31'h0, ready}, 32'h0000_0000, "setup drop");
        load();
        check({31'h0, ready}, 32'h0000_0000, "setup hold");
        wb(1'h1, OFS_FLAGS, 32'hFFFF_FFF7);
        repeat (3) @(posedge clk);
        check({31'h0, ready}, 32'h0000_0001, "setup released");
        // Size registers and hardware status
        {st.ctrl_out_size, st.bulk_size0, st.bulk_size1, st.bulk_out_full} = {7'h25, 10'h200, 10'h003, 1'h1};
        i_host.set_stat(st);
        i_host.pulse(8'h20);
        settle();
        rd(OFS_OUT_SIZE, 32'hFFFF_FFFF, 32'h0000_0025, "out size");
        rd(OFS_BULK_SZ, 32'hFFFF_FFFF, 32'h0000_0200, "bulk size 0");
        wb(1'h1, OFS_FLAGS, 32'h0000_0000);
        rd(OFS_FLAGS, 32'h0000_0010, 32'h0000_0010, "full kept");
        st.bulk_sel = 1'h1;
        i_host.set_stat(st);
        settle();
        rd(OFS_BULK_SZ, 32'hFFFF_FFFF, 32'h0000_0003, "bulk size 1");
        rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
        finish_test();
    end
endmodule : usb_function_irq_route_ep0_in_tb
